// file: verilog/rfr_pkg.sv
// shared constants, types and presets of the receive framer
package rfr_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PROTO = 6'h01;
	localparam logic [5:0] IDX_NRW = 6'h07;
	localparam logic [5:0] IDX_RXW = 6'h08;
	localparam logic [5:0] IDX_STATUS = 6'h0c;
	localparam logic [5:0] IDX_COLH_MASK = 6'h0d;
	localparam logic [5:0] IDX_COLL = 6'h0e;
	localparam logic [5:0] IDX_FIFO_LVL = 6'h1c;
	localparam logic [5:0] IDX_FIFO_DATA = 6'h1f;
	// protocol register fields
	localparam int B_NO_CRC = 7;
	localparam int B_DIR = 6;
	localparam int B_NFC = 5;
	localparam int B_INIT = 4;
	localparam int B_ACT = 3;
	localparam int B_CE = 2;
	localparam logic [7:0] PROTO_RST = 8'h02;
	// status bits
	localparam int S_END = 7;
	localparam int S_SOF = 6;
	localparam int S_FHI = 5;
	localparam int S_CRC = 4;
	localparam int S_PAR = 3;
	localparam int S_FMT = 2;
	localparam int S_COL = 1;
	localparam int S_NRSP = 0;
	localparam logic [5:0] MASK_RST = 6'h00;
	// per-family presets of the two timers
	localparam logic [7:0] RXW_VIC = 8'h1f;
	localparam logic [7:0] RXW_A = 8'h0e;
	localparam logic [7:0] RXW_B = 8'h0e;
	localparam logic [7:0] RXW_OTH = 8'h08;
	localparam logic [7:0] NRW_VIC = 8'h15;
	localparam logic [7:0] NRW_A = 8'h0e;
	localparam logic [7:0] NRW_B = 8'h0e;
	localparam logic [7:0] NRW_OTH = 8'h10;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_NS = 100;
	localparam int RXW_STEP_NS = 9440;
	localparam int NRW_STEP_NS = 37760;
	localparam int RXW_STEP_CYC = (RXW_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int NRW_STEP_CYC = NRW_STEP_NS / CLK_NS;
	localparam logic [9:0] HALF_106 = 10'(CLK_HZ / 212_000);
	localparam logic [9:0] HALF_212 = 10'(CLK_HZ / 424_000);
	localparam logic [9:0] HALF_424 = 10'(CLK_HZ / 848_000);
	localparam logic [9:0] HALF_848 = 10'(CLK_HZ / 1_696_000);
	localparam logic [9:0] HALF_VHI = 10'(CLK_HZ / 52_960);
	localparam logic [9:0] HALF_VLO = 10'(CLK_HZ / 13_240);
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [7:0] FIFO_HI_LVL = 8'd96;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BLANK = 3'b001,
		ST_HUNT = 3'b010,
		ST_DATA = 3'b011
	} rfr_state_e;
	// captured address phase
	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] idx;
	} rfr_aphase_s;
	// one byte leaving the framer
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rfr_byte_s;
endpackage : rfr_pkg

// file: verilog/rfr_receive_framer.sv
// receive decoder, framer, fifo, timers and register slave
// Summary of operation
// - bit collision in reader type A sets flag and requests interrupt
// - collision position split over two registers
// - position counts from zero after start bit
// - decoders held in reset after transmit
// - protocol write presets receive wait time
// - no-response timer flags empty slot
// - protocol write presets no-response wait
// - decoder yields bits and clock, tolerating noise
// - framer builds bytes, drops frame delimiters
// - parity and crc checked, stripped, bytes queued
// - received start of frame sets flag
// - end of receive raises interrupt request
// - interrupt when fifo three quarters full
// - format, parity, crc errors flagged
// - status meaning depends on reader or nfc
// - protocol write selects mode, reloads presets
// - direct mode chooses raw or decoded output
// - mode bit picks reader or nfc
// - nfc bits pick emulation and rate, role and mode bits unused
// - nfc rate codes decoded, emulation always uses HALF_106
// - reader protocol codes decoded, default 00010
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module rfr_receive_framer
#(
	parameter int RXW_STEP = rfr_pkg::RXW_STEP_CYC,
	parameter int NRW_STEP = rfr_pkg::NRW_STEP_CYC,
	parameter int FIFO_DEPTH = 128,
	parameter logic [15:0] CRC_INIT = 16'hffff
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// receiver side
	input wire logic rx_sub,
	input wire logic tx_end,
	input wire logic slot_start,
	// host and direct mode
	output logic irq,
	output logic direct_data,
	output logic direct_clk
);
	import rfr_pkg::*;

	logic [7:0] proto, rxw, nrw, status;
	logic [5:0] mask;
	logic [9:0] col_pos;
	rfr_aphase_s aph;
	logic [7:0] fifo_cnt;
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [6:0] wr_ptr, rd_ptr;
	logic [7:0] sets;
	logic rx_s1, rx_s2;
	logic [7:0] rxw_steps, nrw_steps;
	logic [8:0] rxw_pre, nrw_pre;
	logic sof_ev, nrsp_ev;
	rfr_byte_s push;

	// decoded protocol fields
	logic nfc_mode, type_a, crc_en;
	logic [9:0] half_len;
	assign nfc_mode = proto[B_NFC];
	// parity framing for reader type A and type A emulation
	assign type_a = nfc_mode ? (proto[B_CE] && proto[1:0] == 2'b00) : (proto[4:2] == 3'b010);
	assign crc_en = !proto[B_NO_CRC];

	// half-bit length in clocks from the selected rate
	always_comb
	begin
		half_len = HALF_106;
		if (nfc_mode && !proto[B_CE])
		begin
			case (proto[1:0])
				2'b10: half_len = HALF_212;
				2'b11: half_len = HALF_424;
				default: half_len = HALF_106;
			endcase
		end
		else if (!nfc_mode && proto[4:3] == 2'b00)
			half_len = proto[1] ? HALF_VHI : HALF_VLO;
		else if (!nfc_mode && proto[4:3] == 2'b01)
		begin
			case (proto[1:0])
				2'b01: half_len = HALF_212;
				2'b10: half_len = HALF_424;
				2'b11: half_len = HALF_848;
				default: half_len = HALF_106;
			endcase
		end
	end

	// preset of rx wait and no-response wait per protocol family
	function automatic logic [15:0] preset(input logic [7:0] p);
		if (!p[B_NFC] && p[4:3] == 2'b00)
			return {RXW_VIC, NRW_VIC};
		else if (!p[B_NFC] && p[4:2] == 3'b010)
			return {RXW_A, NRW_A};
		else if (!p[B_NFC] && p[4:2] == 3'b011)
			return {RXW_B, NRW_B};
		return {RXW_OTH, NRW_OTH};
	endfunction : preset

	// bus and register group
	rfr_aphase_s next_aph;
	logic [7:0] next_proto, next_rxw, next_nrw, next_status, view, next_view;
	logic [5:0] next_mask;
	logic [31:0] next_hrdata;
	logic take, pop;
	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0;
	// nfc view hides reader-only collision and slot flags
	assign view = nfc_mode ? {status[7:2], 2'b00} : status;
	// the request pin follows the same view, so hidden reader flags never raise it in nfc mode
	assign next_view = next_proto[B_NFC] ? {next_status[7:2], 2'b00} : next_status;
	always_comb
	begin
		next_aph.wr = take && hwrite;
		next_aph.rd = take && !hwrite;
		next_aph.idx = haddr[7:2];
		next_proto = proto;
		next_rxw = rxw;
		next_nrw = nrw;
		next_mask = mask;
		next_hrdata = 32'h0;
		pop = 1'b0;
		next_status = status | sets;
		// reads answer from the address phase so hrdata is a flop
		if (next_aph.rd)
		begin
			if (next_aph.idx == IDX_PROTO)
				next_hrdata = {24'h0, proto};
			else if (next_aph.idx == IDX_NRW)
				next_hrdata = {24'h0, nrw};
			else if (next_aph.idx == IDX_RXW)
				next_hrdata = {24'h0, rxw};
			else if (next_aph.idx == IDX_STATUS)
			begin
				next_hrdata = {24'h0, view};
				next_status = sets; // clear on read, set wins
			end
			else if (next_aph.idx == IDX_COLH_MASK)
				next_hrdata = {24'h0, col_pos[9:8], mask};
			else if (next_aph.idx == IDX_COLL)
				next_hrdata = {24'h0, col_pos[7:0]};
			else if (next_aph.idx == IDX_FIFO_LVL)
				next_hrdata = {24'h0, fifo_cnt};
			else if (next_aph.idx == IDX_FIFO_DATA)
			begin
				next_hrdata = {24'h0, fifo_mem[rd_ptr]};
				pop = fifo_cnt != 8'h0;
			end
		end
		// writes commit in the data phase
		if (aph.wr)
		begin
			if (aph.idx == IDX_PROTO)
			begin
				next_proto = hwdata[7:0];
				{next_rxw, next_nrw} = preset(hwdata[7:0]);
			end
			else if (aph.idx == IDX_NRW)
				next_nrw = hwdata[7:0];
			else if (aph.idx == IDX_RXW)
				next_rxw = hwdata[7:0];
			else if (aph.idx == IDX_COLH_MASK)
				next_mask = hwdata[5:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph <= '0;
			proto <= PROTO_RST;
			rxw <= RXW_VIC;
			nrw <= NRW_VIC;
			mask <= MASK_RST;
			status <= 8'h0;
			hrdata <= 32'h0;
			irq <= 1'b0;
		end
		else
		begin
			aph <= next_aph;
			proto <= next_proto;
			rxw <= next_rxw;
			nrw <= next_nrw;
			mask <= next_mask;
			status <= next_status;
			hrdata <= next_hrdata;
			// masked sticky flags drive the request pin
			irq <= |(next_view & ~{2'b00, next_mask});
		end
	end

	// timer group: blanking after transmit and empty-slot detection
	logic [7:0] next_rxw_steps, next_nrw_steps;
	logic [8:0] next_rxw_pre, next_nrw_pre;
	logic blanking;
	assign blanking = rxw_steps != 8'h0;
	always_comb
	begin
		next_rxw_steps = rxw_steps;
		next_rxw_pre = rxw_pre - 9'd1;
		next_nrw_steps = nrw_steps;
		next_nrw_pre = nrw_pre - 9'd1;
		nrsp_ev = 1'b0;
		if (tx_end)
		begin
			next_rxw_steps = rxw;
			next_rxw_pre = 9'(RXW_STEP - 1);
		end
		else if (blanking && rxw_pre == 9'h0)
		begin
			next_rxw_steps = rxw_steps - 8'd1;
			next_rxw_pre = 9'(RXW_STEP - 1);
		end
		if (slot_start)
		begin
			next_nrw_steps = nrw;
			next_nrw_pre = 9'(NRW_STEP - 1);
		end
		else if (sof_ev)
			next_nrw_steps = 8'h0; // a response began in time
		else if (nrw_steps != 8'h0 && nrw_pre == 9'h0)
		begin
			next_nrw_steps = nrw_steps - 8'd1;
			next_nrw_pre = 9'(NRW_STEP - 1);
			nrsp_ev = nrw_steps == 8'd1;
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rxw_steps <= 8'h0;
			rxw_pre <= 9'h0;
			nrw_steps <= 8'h0;
			nrw_pre <= 9'h0;
		end
		else
		begin
			rxw_steps <= next_rxw_steps;
			rxw_pre <= next_rxw_pre;
			nrw_steps <= next_nrw_steps;
			nrw_pre <= next_nrw_pre;
		end
	end

	// decoder and framer group
	rfr_state_e state, next_state;
	logic [9:0] hcnt, next_hcnt, hi_cnt, next_hi_cnt, bit_idx, next_bit_idx, next_col_pos;
	logic h1, next_h1, second, next_second, start_bit, next_start_bit;
	logic [3:0] bcnt, next_bcnt;
	logic [7:0] sr, next_sr, hold0, next_hold0, hold1, next_hold1;
	logic [1:0] held, next_held;
	logic [15:0] crc, next_crc;
	logic dbit, dclk, next_dbit, next_dclk, half_val, dval;
	// majority over the half period rides out short glitches
	assign half_val = hi_cnt > (half_len >> 1);
	always_comb
	begin
		next_state = state;
		next_hcnt = hcnt + 10'd1;
		next_hi_cnt = hi_cnt + {9'h0, rx_s2};
		next_h1 = h1;
		next_second = second;
		next_start_bit = start_bit;
		next_bcnt = bcnt;
		next_sr = sr;
		next_hold0 = hold0;
		next_hold1 = hold1;
		next_held = held;
		next_crc = crc;
		next_bit_idx = bit_idx;
		next_col_pos = col_pos;
		next_dbit = dbit;
		next_dclk = 1'b0;
		sets = {7'h0, nrsp_ev};
		sof_ev = 1'b0;
		push = '0;
		dval = h1 || !half_val;
		case (state)
			ST_IDLE:
				next_state = blanking ? ST_BLANK : ST_HUNT;
			ST_BLANK:
				if (!blanking)
					next_state = ST_HUNT;
			ST_HUNT:
			begin
				next_hcnt = 10'd1;
				next_hi_cnt = {9'h0, rx_s2};
				next_second = 1'b0;
				next_start_bit = 1'b1;
				next_bcnt = 4'h0;
				next_held = 2'b00;
				next_crc = CRC_INIT;
				next_bit_idx = 10'h0;
				if (rx_s2)
					next_state = ST_DATA; // first half of start bit
			end
			ST_DATA:
			begin
				if (hcnt == half_len)
				begin
					// this edge's sample opens the next half, so a half spans exactly half_len clocks
					next_hcnt = 10'd1;
					next_hi_cnt = {9'h0, rx_s2};
					next_second = !second;
					next_h1 = half_val;
					if (second && !h1 && !half_val)
					begin
						// two silent halves close the frame
						next_state = ST_HUNT;
						sets[S_END] = 1'b1;
						if (bcnt != 4'h0)
							sets[S_FMT] = 1'b1;
						if (crc_en && (crc != 16'h0 || held != 2'b10))
							sets[S_CRC] = 1'b1;
					end
					else if (second && start_bit)
					begin
						next_start_bit = 1'b0; // delimiter never reaches the bytes
						sof_ev = 1'b1;
						sets[S_SOF] = 1'b1;
					end
					else if (second)
					begin
						next_dbit = dval;
						next_dclk = 1'b1;
						if (h1 && half_val && type_a)
						begin
							sets[S_COL] = 1'b1;
							next_col_pos = bit_idx;
						end
						if (bcnt == 4'd8)
						begin
							// odd parity bit is checked and dropped
							next_bcnt = 4'h0;
							if (!(^sr ^ dval))
								sets[S_PAR] = 1'b1;
						end
						else
						begin
							next_sr = {dval, sr[7:1]};
							next_bit_idx = bit_idx + 10'd1;
							next_crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ dval) ? CRC_POLY : 16'h0);
							next_bcnt = bcnt + 4'd1;
							if (bcnt == 4'd7)
							begin
								next_bcnt = type_a ? 4'd8 : 4'd0;
								// last two bytes wait so crc never enters the fifo
								if (!crc_en)
									push = '{valid: 1'b1, data: {dval, sr[7:1]}};
								else
								begin
									next_hold0 = {dval, sr[7:1]};
									next_hold1 = hold0;
									next_held = held == 2'b00 ? 2'b01 : 2'b10;
									push = '{valid: held == 2'b10, data: hold1};
								end
							end
						end
					end
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		if (fifo_cnt == FIFO_HI_LVL - 8'd1 && push.valid && !pop)
			sets[S_FHI] = 1'b1;
		if (push.valid && fifo_cnt == 8'(FIFO_DEPTH) && !pop)
			sets[S_FMT] = 1'b1; // overflow drops the byte
		if (blanking)
			next_state = ST_BLANK;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= ST_IDLE;
			hcnt <= 10'h0;
			hi_cnt <= 10'h0;
			h1 <= 1'b0;
			second <= 1'b0;
			start_bit <= 1'b0;
			bcnt <= 4'h0;
			sr <= 8'h0;
			hold0 <= 8'h0;
			hold1 <= 8'h0;
			held <= 2'b00;
			crc <= 16'h0;
			bit_idx <= 10'h0;
			col_pos <= 10'h0;
			dbit <= 1'b0;
			dclk <= 1'b0;
		end
		else
		begin
			state <= next_state;
			hcnt <= next_hcnt;
			hi_cnt <= next_hi_cnt;
			h1 <= next_h1;
			second <= next_second;
			start_bit <= next_start_bit;
			bcnt <= next_bcnt;
			sr <= next_sr;
			hold0 <= next_hold0;
			hold1 <= next_hold1;
			held <= next_held;
			crc <= next_crc;
			bit_idx <= next_bit_idx;
			col_pos <= next_col_pos;
			dbit <= next_dbit;
			dclk <= next_dclk;
		end
	end

	// input synchroniser, fifo and direct-mode output
	logic [7:0] next_fifo_cnt;
	logic do_push;
	assign do_push = push.valid && (fifo_cnt != 8'(FIFO_DEPTH) || pop);
	assign next_fifo_cnt = fifo_cnt + {7'h0, do_push} - {7'h0, pop};
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
			wr_ptr <= 7'h0;
			rd_ptr <= 7'h0;
			fifo_cnt <= 8'h0;
			direct_data <= 1'b0;
			direct_clk <= 1'b0;
		end
		else
		begin
			rx_s1 <= rx_sub;
			rx_s2 <= rx_s1;
			wr_ptr <= wr_ptr + {6'h0, do_push};
			rd_ptr <= rd_ptr + {6'h0, pop};
			fifo_cnt <= next_fifo_cnt;
			direct_data <= proto[B_DIR] ? dbit : rx_s2;
			direct_clk <= proto[B_DIR] ? dclk : 1'b0;
		end
	end
	// storage carries no reset
	always_ff @(posedge hclk)
	begin
		if (do_push)
			fifo_mem[wr_ptr] <= push.data;
	end

	// checks
	a_blank_holds_dec: assert property (@(posedge hclk) disable iff (!hresetn)
		blanking |=> state == ST_BLANK) else $error("decoder active while blanking");
	a_proto_presets: assert property (@(posedge hclk) disable iff (!hresetn)
		aph.wr && aph.idx == IDX_PROTO |=> {rxw, nrw} == preset(proto)) else $error("presets not loaded");
	a_col_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		sets[S_COL] |=> status[S_COL] && col_pos == $past(bit_idx)) else $error("collision not recorded");
	a_nrsp_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		nrsp_ev && !sof_ev |=> status[S_NRSP] ##1 1) else $error("slot flag missing");
	a_sof_stops_slot: assert property (@(posedge hclk) disable iff (!hresetn)
		sof_ev && !slot_start |=> nrw_steps == 8'h0 && status[S_SOF]) else $error("sof not handled");
	a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == |(view & ~{2'b00, mask})) else $error("irq mismatch");
	a_fifo_hi_lvl: assert property (@(posedge hclk) disable iff (!hresetn)
		fifo_cnt == FIFO_HI_LVL && $past(fifo_cnt) == FIFO_HI_LVL - 8'd1 |-> status[S_FHI]) else $error("no hi flag");
	a_fifo_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		fifo_cnt <= 8'(FIFO_DEPTH)) else $error("fifo count overrun");
	a_dir_raw: assert property (@(posedge hclk) disable iff (!hresetn)
		!proto[B_DIR] && $stable(proto) |=> direct_data == $past(rx_s2)) else $error("raw output wrong");
	c_frame_end: cover property (@(posedge hclk) disable iff (!hresetn) sets[S_END] && !sets[S_CRC]);
	c_collision: cover property (@(posedge hclk) disable iff (!hresetn) sets[S_COL]);
	c_no_resp: cover property (@(posedge hclk) disable iff (!hresetn) nrsp_ev);
	c_fifo_pop: cover property (@(posedge hclk) disable iff (!hresetn) pop ##1 pop);
endmodule : rfr_receive_framer

// file: verification/rfr_tag_model.sv
// tag-side model: replays queued bit symbols as subcarrier halves
`timescale 1ns/100ps
module rfr_tag_model
(
	// clock
	input wire logic hclk,
	// control from the bench
	input wire logic go,
	input wire logic [9:0] half_len,
	// subcarrier towards the framer, busy back to the bench
	output logic rx_sub,
	output logic busy
);
	// symbol codes: 0 zero, 1 one, 2 collision, 3 end of frame
	logic [1:0] sym_q[$];
	logic [1:0] s;
	// no subcarrier between frames, so the line rests low rather than holding the last half
	initial
	begin
		rx_sub = 1'b0;
		busy = 1'b0;
		forever
		begin
			@(posedge hclk);
			if (go)
			begin
				busy <= 1'b1;
				while (sym_q.size() > 0)
				begin
					s = sym_q.pop_front();
					rx_sub <= (s == 2'd1) || (s == 2'd2);
					repeat (half_len) @(posedge hclk);
					rx_sub <= (s == 2'd0) || (s == 2'd2);
					repeat (half_len) @(posedge hclk);
				end
				rx_sub <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule : rfr_tag_model

// file: verification/tb_top.sv
// self-checking bench of the receive framer
`timescale 1ns/100ps
module tb_top;
	import rfr_pkg::*;
	typedef struct packed {logic [5:0] idx; logic [7:0] val; logic [7:0] msk;} rfr_note_s;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0;
	logic tx_end = 1'b0;
	logic slot_start = 1'b0;
	logic go = 1'b0;
	logic hreadyout, hresp, irq, direct_data, direct_clk, rx_sub, busy, rd_pend;
	logic [31:0] hrdata;
	logic [31:0] rnd = 32'hec84;
	logic [15:0] crc;
	logic [15:0] c;
	logic [23:0] ptab [4] = '{{8'h02, RXW_VIC, NRW_VIC}, {8'h08, RXW_A, NRW_A}, {8'h0c, RXW_B, NRW_B},
		{8'h1a, RXW_OTH, NRW_OTH}};
	rfr_note_s note_q[$];
	rfr_note_s nt;
	logic [7:0] dq[$];
	int bad_count = 0;
	int n_compared = 0;
	int n_dclk = 0;
	int d0;
	always #50 hclk = ~hclk;
	// short timer steps keep the blanking and no-response waits brief
	rfr_receive_framer #(.RXW_STEP(4), .NRW_STEP(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_sub(rx_sub), .tx_end(tx_end),
		.slot_start(slot_start), .irq(irq), .direct_data(direct_data), .direct_clk(direct_clk));
	rfr_tag_model i_tag (.hclk(hclk), .go(go), .half_len(HALF_848), .rx_sub(rx_sub), .busy(busy));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev8[i] = v[7 - i];
	endfunction : rev8
	task automatic chk_rd(input rfr_note_s n, input logic [31:0] got);
		n_compared++;
		if ((got & {24'hffffff, n.msk}) !== {24'h0, n.val & n.msk})
		begin
			bad_count++;
			$display("MISMATCH reg %h expected %h seen %h", n.idx, n.val, got);
		end
	endtask : chk_rd
	task automatic chk_irq(input logic e);
		n_compared++;
		if (irq !== e)
		begin
			bad_count++;
			$display("MISMATCH irq expected %b seen %b", e, irq);
		end
	endtask : chk_irq
	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk_val
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// one single ahb transfer; read data lands in the watcher at the data-phase edge
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rnd = xs(rnd);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? {24'h0, wd} : rnd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : xfer
	// idle cycle after a write, though a read straight after would already return the new value
	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		xfer(1'b1, idx, v);
		@(posedge hclk);
	endtask : wr
	task automatic rd(input logic [5:0] idx, input logic [7:0] v, input logic [7:0] m);
		note_q.push_back('{idx, v, m});
		xfer(1'b0, idx, 8'h00);
	endtask : rd
	task automatic drain();
		while (dq.size() > 0)
			rd(IDX_FIFO_DATA, dq.pop_front(), 8'hff);
	endtask : drain
	task automatic slot();
		slot_start <= 1'b1;
		@(posedge hclk);
		slot_start <= 1'b0;
		repeat (12) @(posedge hclk);
	endtask : slot
	// frame building: start bit, lsb-first data with odd parity, running crc over data bits
	task automatic frame_start();
		crc = 16'hffff;
		i_tag.sym_q.push_back(2'd1);
	endtask : frame_start
	task automatic add_byte(input logic [7:0] b, input logic badp, input logic keep);
		for (int i = 0; i < 8; i++)
		begin
			i_tag.sym_q.push_back({1'b0, b[i]});
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? CRC_POLY : 16'h0);
		end
		i_tag.sym_q.push_back({1'b0, ~^b ^ badp});
		if (keep)
			dq.push_back(b);
	endtask : add_byte
	task automatic add_rnd(input int n);
		repeat (n)
		begin
			rnd = xs(rnd);
			add_byte(rnd[7:0], 1'b0, 1'b1);
		end
	endtask : add_rnd
	task automatic send(input int w);
		i_tag.sym_q.push_back(2'd3);
		tx_end <= 1'b1;
		@(posedge hclk);
		tx_end <= 1'b0;
		repeat (w) @(posedge hclk);
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		do @(posedge hclk); while (busy);
		repeat (20) @(posedge hclk);
	endtask : send
	// watcher: each completed read data phase closes the oldest note
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_pend <= 1'b0;
		else if (hreadyout === 1'b1)
		begin
			if (rd_pend)
			begin
				nt = note_q.pop_front();
				chk_rd(nt, hrdata);
				chk_val("hresp", 32'h0, {31'h0, hresp});
			end
			rd_pend <= hsel && htrans[1] && !hwrite;
		end
	end
	// counts decoded-bit clock pulses on the direct output
	always @(posedge hclk)
	begin
		if (direct_clk === 1'b1)
			n_dclk++;
	end
	// watchdog, sized well past the ~15k cycles the tests need
	initial
	begin
		#6_000_000;
		bad_count++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(IDX_PROTO, PROTO_RST, 8'hff);
		rd(IDX_RXW, RXW_VIC, 8'hff);
		rd(IDX_NRW, NRW_VIC, 8'hff);
		rd(IDX_COLH_MASK, 8'h00, 8'hff);
		wr(IDX_STATUS, 8'hff);
		rd(IDX_STATUS, 8'h00, 8'hff);
		rd(6'h3f, 8'h00, 8'hff);
		$display("test reset done");
		foreach (ptab[i])
		begin
			wr(IDX_RXW, 8'h33);
			wr(IDX_NRW, 8'h44);
			wr(IDX_PROTO, ptab[i][23:16]);
			rd(IDX_PROTO, ptab[i][23:16], 8'hff);
			rd(IDX_RXW, ptab[i][15:8], 8'hff);
			rd(IDX_NRW, ptab[i][7:0], 8'hff);
		end
		wr(IDX_RXW, 8'h5a);
		rd(IDX_RXW, 8'h5a, 8'hff);
		$display("test presets done");
		wr(IDX_PROTO, 8'h08);
		wr(IDX_NRW, 8'h02);
		for (int m = 0; m < 2; m++)
		begin
			wr(IDX_COLH_MASK, {7'h0, m[0]});
			slot();
			chk_irq(1'b0);
			repeat (12) @(posedge hclk);
			chk_irq(~m[0]);
			rd(IDX_STATUS, 8'h01, 8'hff);
			rd(IDX_STATUS, 8'h00, 8'hff);
			repeat (2) @(posedge hclk);
			chk_irq(1'b0);
		end
		wr(IDX_COLH_MASK, 8'h00);
		wr(IDX_PROTO, 8'h21);
		wr(IDX_NRW, 8'h02);
		slot();
		repeat (12) @(posedge hclk);
		chk_irq(1'b0);
		rd(IDX_STATUS, 8'h00, 8'hff);
		$display("test no-response done");
		wr(IDX_PROTO, 8'h8b);
		frame_start();
		add_rnd(1);
		send(80);
		chk_irq(1'b1);
		rd(IDX_STATUS, 8'hc0, 8'hff);
		rd(IDX_FIFO_LVL, 8'h01, 8'hff);
		drain();
		frame_start();
		add_rnd(100);
		send(80);
		rd(IDX_STATUS, 8'he0, 8'he0);
		rd(IDX_FIFO_LVL, 8'd100, 8'hff);
		drain();
		rd(IDX_FIFO_LVL, 8'h00, 8'hff);
		$display("test frames done");
		frame_start();
		add_rnd(34);
		i_tag.sym_q.push_back(2'd2);
		send(80);
		rd(IDX_STATUS, 8'h02, 8'h02);
		rd(IDX_COLL, 8'h10, 8'hff);
		rd(IDX_COLH_MASK, 8'h40, 8'hc0);
		rd(IDX_FIFO_LVL, 8'd34, 8'hff);
		drain();
		$display("test collision done");
		wr(IDX_RXW, 8'h40);
		frame_start();
		add_rnd(1);
		send(0);
		dq.delete();
		rd(IDX_STATUS, 8'h00, 8'hff);
		rd(IDX_FIFO_LVL, 8'h00, 8'hff);
		$display("test blanking done");
		// decoded direct mode: one clock per data and parity bit, data shows the last bit
		wr(IDX_PROTO, 8'hcb);
		d0 = n_dclk;
		frame_start();
		add_rnd(1);
		send(80);
		chk_val("direct_clk pulses", 32'd9, n_dclk - d0);
		chk_val("direct_data", {31'h0, ~^rnd[7:0]}, {31'h0, direct_data});
		rd(IDX_STATUS, 8'hc0, 8'hff);
		drain();
		$display("test direct done");
		wr(IDX_PROTO, 8'h0b);
		for (int k = 0; k < 2; k++)
		begin
			frame_start();
			add_rnd(2);
			c = crc;
			add_byte(rev8(c[15:8]), 1'b0, 1'b0);
			add_byte(rev8(c[7:0]) ^ {7'h0, k[0]}, 1'b0, 1'b0);
			send(80);
			rd(IDX_STATUS, {3'b110, k[0], 4'h0}, 8'hff);
			if (k == 0)
				rd(IDX_FIFO_LVL, 8'h02, 8'hff);
			if (k == 0)
				drain();
			dq.delete();
		end
		$display("test crc done");
		wr(IDX_PROTO, 8'h8b);
		frame_start();
		add_byte(8'h3c, 1'b1, 1'b0);
		send(80);
		chk_irq(1'b1);
		rd(IDX_STATUS, 8'h08, 8'h08);
		$display("test parity done");
		wrap_up();
	end
endmodule : tb_top
